//--- hw/psl_regs.svh
// Purpose: Constants for the shared strap and indicator pin block.
// Assumes: 40 MHz device clock.
// Notes: Definitions only.
`ifndef PSL_REGS_SVH
`define PSL_REGS_SVH

// ==========================================================
// Pin layout
`define PSL_PINS 5
`define PSL_PIN_ACT 0
`define PSL_PIN_COL 1
`define PSL_PIN_LNK 2
`define PSL_PIN_TX 3
`define PSL_PIN_RX 4

// ==========================================================
// Reset and timing
`define PSL_PINS_RST 5'h00
`define PSL_FILL_LAST 2'h3
`define PSL_FILL_STEP 2'h1
`define PSL_COL_HOLD_MS 70
`define PSL_CLK_KHZ 40000
`define PSL_HOLD_W 22
`define PSL_HOLD_ZERO 22'h000000
`define PSL_HOLD_STEP 22'h000001

`endif

//--- hw/psl_pkg.sv
// Purpose: Types for the shared strap and indicator pin block.
// Assumes: psl_regs.svh supplies the widths.
// Notes: None.
`include "psl_regs.svh"

package psl_pkg;

  // ==========================================================
  // Pin block state
  typedef enum logic {PSL_SAMPLE, PSL_RUN} psl_phase_t;

  typedef struct packed {
    psl_phase_t phase;
    logic [1:0] fill;
    logic [`PSL_PINS-1:0] sync1;
    logic [`PSL_PINS-1:0] sync2;
    logic [`PSL_PINS-1:0] sync3;
    logic [`PSL_PINS-1:0] strap;
    logic [`PSL_PINS-1:0] addr;
    logic [`PSL_PINS-1:0] pin_out;
    logic [`PSL_PINS-1:0] pin_oe;
    logic done;
  } psl_state_t;

  // ==========================================================
  // Collision hold state
  typedef struct packed {
    logic busy;
    logic [`PSL_HOLD_W-1:0] cnt;
  } psl_hold_t;

endpackage

//--- hw/psl_hold.sv
// Purpose: Retriggerable hold timer that stretches collision events.
// Assumes: trig and clear come from logic on clk.
// Notes: busy stands HOLD cycles after the last trig.
`timescale 1ns/100ps
`default_nettype none
`include "psl_regs.svh"

module psl_hold
  import psl_pkg::*;
#(
  parameter int unsigned HOLD = `PSL_COL_HOLD_MS * `PSL_CLK_KHZ
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic clear,
  input wire logic trig,
  output logic busy
);

  localparam logic [`PSL_HOLD_W-1:0] HOLD_LD = `PSL_HOLD_W'(HOLD - 1);

  psl_hold_t q;
  psl_hold_t d;

  // ==========================================================
  // Hold counter
  always_comb begin
    d = q;
    if (clear) begin
      d.busy = 1'b0;
      d.cnt = `PSL_HOLD_ZERO;
    end else if (trig) begin
      // A new collision restarts the full interval
      d.busy = 1'b1;
      d.cnt = HOLD_LD;
    end else if (q.busy) begin
      if (q.cnt == `PSL_HOLD_ZERO) begin
        d.busy = 1'b0;
      end else begin
        d.cnt = q.cnt - `PSL_HOLD_STEP;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign busy = q.busy;

  // ==========================================================
  // Checks
  sequence s_fresh_trig;
    trig && !clear;
  endsequence

  a_hold_restart: assert property (@(posedge clk) disable iff (!nrst)
    s_fresh_trig |=> (q.busy && q.cnt == HOLD_LD))
    else $error("hold did not restart");

  a_hold_drop: assert property (@(posedge clk) disable iff (!nrst)
    (q.busy && q.cnt == `PSL_HOLD_ZERO && !trig && !clear) |=> !q.busy)
    else $error("hold did not end");

  a_hold_keep: assert property (@(posedge clk) disable iff (!nrst)
    (q.busy && q.cnt != `PSL_HOLD_ZERO && !clear) |=> q.busy)
    else $error("hold ended early");

endmodule

`default_nettype wire

//--- hw/psl_pins.sv
// Purpose: Shared strap and status indicator pins of an Ethernet PHY.
// Assumes: nrst is the power-on or hardware reset; sw_rst, rx_act,
//   tx_act, link_up and col_det come from logic on clk.
// Notes: Pads are sampled after reset release, then driven as LEDs.
`timescale 1ns/100ps
`default_nettype none
`include "psl_regs.svh"

module psl_pins
  import psl_pkg::*;
#(
  parameter int unsigned COL_HOLD_CYC = `PSL_COL_HOLD_MS * `PSL_CLK_KHZ
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic sw_rst,
  input wire logic rx_act,
  input wire logic tx_act,
  input wire logic link_up,
  input wire logic col_det,
  input wire logic [`PSL_PINS-1:0] pin_in,
  output logic [`PSL_PINS-1:0] pin_out,
  output logic [`PSL_PINS-1:0] pin_oe,
  output logic [`PSL_PINS-1:0] management_station_address,
  output logic strap_done
);

  psl_state_t q;
  psl_state_t d;
  logic col_hold;
  logic col_trig;
  logic [`PSL_PINS-1:0] led_on;

  // ==========================================================
  // Collision stretch
  // Only run once the pins are outputs; software reset clears it.
  assign col_trig = col_det && q.done && !sw_rst;

  psl_hold #(
    .HOLD(COL_HOLD_CYC)
  ) u_hold (
    .clk(clk),
    .nrst(nrst),
    .clear(sw_rst),
    .trig(col_trig),
    .busy(col_hold)
  );

  // ==========================================================
  // Indicator sources
  always_comb begin
    led_on = `PSL_PINS_RST;
    led_on[`PSL_PIN_ACT] = rx_act || tx_act;
    led_on[`PSL_PIN_COL] = col_det || col_hold;
    led_on[`PSL_PIN_LNK] = link_up;
    led_on[`PSL_PIN_TX] = tx_act;
    led_on[`PSL_PIN_RX] = rx_act;
  end

  // ==========================================================
  // Strap capture and pin drive
  always_comb begin
    d = q;
    d.sync1 = pin_in;
    d.sync2 = q.sync1;
    d.sync3 = q.sync2;
    unique case (q.phase)
      PSL_SAMPLE: begin
        // Pads are released until a settled sample is taken
        d.pin_oe = `PSL_PINS_RST;
        d.pin_out = `PSL_PINS_RST;
        if (q.fill != `PSL_FILL_LAST) begin
          d.fill = q.fill + `PSL_FILL_STEP;
        end else if (q.sync2 == q.sync3) begin
          d.strap = q.sync3;
          d.addr = q.sync3;
          d.done = 1'b1;
          d.phase = PSL_RUN;
          d.pin_oe = ~`PSL_PINS_RST;
          d.pin_out = q.sync3;
        end
      end
      PSL_RUN: begin
        // Strap and address never move here, software reset or not
        d.pin_oe = ~`PSL_PINS_RST;
        if (sw_rst) begin
          d.pin_out = q.strap;
        end else begin
          d.pin_out = q.strap ^ led_on;
        end
      end
    endcase
  end

  // Reset leaves the pads undriven in the sample phase
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign pin_out = q.pin_out;
  assign pin_oe = q.pin_oe;
  assign management_station_address = q.addr;
  assign strap_done = q.done;

  // ==========================================================
  // Checks
  sequence s_running;
    q.done && !sw_rst;
  endsequence

  sequence s_capture;
    $rose(q.done);
  endsequence

  a_oe_sample: assert property (@(posedge clk) disable iff (!nrst)
    !q.done |-> (q.pin_oe == `PSL_PINS_RST))
    else $error("pin driven before strap capture");

  a_oe_run: assert property (@(posedge clk) disable iff (!nrst)
    s_capture |-> (q.pin_oe == ~`PSL_PINS_RST))
    else $error("pins not driven after capture");

  a_oe_swrst: assert property (@(posedge clk) disable iff (!nrst)
    (q.done && sw_rst) |=> (q.pin_oe == ~`PSL_PINS_RST))
    else $error("pin released during software reset");

  a_strap_kept: assert property (@(posedge clk) disable iff (!nrst)
    (q.done && $past(q.done)) |-> ($stable(q.addr) && $stable(q.strap)))
    else $error("strap changed after capture");

  a_addr_take: assert property (@(posedge clk) disable iff (!nrst)
    s_capture |-> (q.addr == $past(q.sync3) && q.strap == q.addr))
    else $error("address differs from sampled pins");

  a_act_led: assert property (@(posedge clk) disable iff (!nrst)
    s_running |=> (q.pin_out[`PSL_PIN_ACT] ==
      ($past(rx_act || tx_act) ^ q.strap[`PSL_PIN_ACT])))
    else $error("activity indicator wrong");

  a_col_led: assert property (@(posedge clk) disable iff (!nrst)
    (s_running ##0 col_det) |=> ##1 ($past(sw_rst) ||
      q.pin_out[`PSL_PIN_COL] == !q.strap[`PSL_PIN_COL]))
    else $error("collision indicator not held");

  a_lnk_led: assert property (@(posedge clk) disable iff (!nrst)
    s_running |=> (q.pin_out[`PSL_PIN_LNK] ==
      ($past(link_up) ^ q.strap[`PSL_PIN_LNK])))
    else $error("link indicator wrong");

  a_tx_led: assert property (@(posedge clk) disable iff (!nrst)
    s_running |=> (q.pin_out[`PSL_PIN_TX] ==
      ($past(tx_act) ^ q.strap[`PSL_PIN_TX])))
    else $error("transmit indicator wrong");

  a_rx_led: assert property (@(posedge clk) disable iff (!nrst)
    s_running |=> (q.pin_out[`PSL_PIN_RX] ==
      ($past(rx_act) ^ q.strap[`PSL_PIN_RX])))
    else $error("receive indicator wrong");

  a_swrst_idle: assert property (@(posedge clk) disable iff (!nrst)
    (q.done && sw_rst) |=> (q.pin_out == q.strap))
    else $error("indicator active during software reset");

  sequence s_col_lit;
    q.done && !sw_rst && (col_det || col_hold);
  endsequence

  sequence s_col_dark;
    q.done && !sw_rst && !col_det && !col_hold;
  endsequence

  // Held cycles must light the pad even with col_det long gone
  a_col_held: assert property (@(posedge clk) disable iff (!nrst)
    s_col_lit |=> (q.pin_out[`PSL_PIN_COL] == !q.strap[`PSL_PIN_COL]))
    else $error("collision indicator dark while held");

  a_col_off: assert property (@(posedge clk) disable iff (!nrst)
    s_col_dark |=> (q.pin_out[`PSL_PIN_COL] == q.strap[`PSL_PIN_COL]))
    else $error("collision indicator lit with no collision");

  a_sample_low: assert property (@(posedge clk) disable iff (!nrst)
    !q.done |-> (q.pin_out == `PSL_PINS_RST))
    else $error("pad level driven before capture");

  a_fill_wait: assert property (@(posedge clk) disable iff (!nrst)
    (!q.done && q.fill != `PSL_FILL_LAST) |=> !q.done)
    else $error("strap taken before synchroniser filled");

  a_oe_held: assert property (@(posedge clk) disable iff (!nrst)
    q.done |-> (q.pin_oe == ~`PSL_PINS_RST))
    else $error("pin released after capture");

  a_done_kept: assert property (@(posedge clk) disable iff (!nrst)
    q.done |=> q.done)
    else $error("capture lost before hardware reset");

  // Software reset must not leave a stale stretch behind it
  a_hold_swclr: assert property (@(posedge clk) disable iff (!nrst)
    sw_rst |=> !col_hold)
    else $error("collision hold survived software reset");

endmodule

`default_nettype wire

//--- bench/psl_pads.sv
// Purpose: Pad model: strap resistor with a status indicator in series.
// Assumes: One resistor per pad sets its strap level.
// Notes: The resistor wins whenever the block is not driving.
`timescale 1ns/100ps
`default_nettype none

module psl_pads (
  input wire logic [4:0] pin_out,
  input wire logic [4:0] pin_oe,
  input wire logic [4:0] pull,
  output logic [4:0] pin_in
);
  // ==========================================================
  // Pad level
  // A released pad settles to its resistor, never to the last driven value
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      pin_in[i] = pin_oe[i] ? pin_out[i] : pull[i];
    end
  end
endmodule
`default_nettype wire

//--- bench/psl_tb.sv
// Purpose: Self-checking bench for the shared strap and indicator pins.
// Assumes: Collision hold shortened to HOLD cycles.
// Notes: Expected pad levels are queued and checked after each edge.
`timescale 1ns/100ps
`default_nettype none

module testbench;
  localparam int unsigned HOLD = 20;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic sw_rst = 1'b0;
  logic rx_act = 1'b0;
  logic tx_act = 1'b0;
  logic link_up = 1'b0;
  logic col_det = 1'b0;
  logic [4:0] pull = 5'h00;
  logic [4:0] pin_in, pin_out, pin_oe, addr;
  logic strap_done;
  logic [4:0] exp_q[$];
  logic [4:0] msk_q[$];
  int bad_count = 0;
  int checks = 0;
  int cycles = 0;

  always #12.5 clk = ~clk;

  psl_pins #(.COL_HOLD_CYC(HOLD)) DUT (.clk(clk), .nrst(nrst),
    .sw_rst(sw_rst), .rx_act(rx_act), .tx_act(tx_act), .link_up(link_up),
    .col_det(col_det), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .management_station_address(addr),
    .strap_done(strap_done));
  psl_pads pads (.pin_out(pin_out), .pin_oe(pin_oe), .pull(pull),
    .pin_in(pin_in));

  // ==========================================================
  // Compare and verdict
  task automatic cmp(input string what, input logic [4:0] e,
                     input logic [4:0] g, input logic [4:0] m);
    checks++;
    if ((g & m) !== (e & m)) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, e & m, g & m);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 1000) begin
      bad_count++;
      give_verdict();
    end
  end

  // Checked 1 ns after the edge so the registered outputs have landed
  always @(posedge clk) begin
    #1;
    if (exp_q.size() > 0) begin
      cmp("pin_oe", 5'h1F, pin_oe, 5'h1F);
      cmp("pin_out", exp_q.pop_front(), pin_out, msk_q.pop_front());
    end
  end

  // ==========================================================
  // Drivers
  // v is {rx, tx, link, col}; c is the expected collision indication
  task automatic step(input logic s, input logic [3:0] v, input logic c,
                      input logic [4:0] m);
    @(negedge clk);
    sw_rst = s;
    {rx_act, tx_act, link_up, col_det} = v;
    exp_q.push_back(s ? pull : pull ^ {v[3:1], c, v[3] | v[2]});
    msk_q.push_back(m);
  endtask

  task automatic hw_reset(input logic [4:0] p);
    @(negedge clk);
    nrst = 1'b0;
    {rx_act, tx_act, link_up, col_det, sw_rst} = 5'h00;
    pull = p;
    repeat (12) @(negedge clk);
    cmp("pin_oe", 5'h00, pin_oe, 5'h1F);
    nrst = 1'b1;
    @(negedge clk);
    cmp("pin_oe", 5'h00, pin_oe, 5'h1F);
    for (int i = 0; i < 10 && strap_done !== 1'b1; i++) @(negedge clk);
    cmp("strap_done", 5'h01, {4'h0, strap_done}, 5'h01);
    cmp("address", p, addr, 5'h1F);
    cmp("pin_oe", 5'h1F, pin_oe, 5'h1F);
    cmp("pin_out", p, pin_out, 5'h1F);
  endtask

  // ==========================================================
  // Tests
  initial begin
    void'($urandom(76));
    for (int r = 0; r < 3; r++) begin
      hw_reset(5'($urandom()));
      for (int k = 0; k < 40; k++) begin
        step(1'b0, {3'($urandom()), 1'b0}, 1'b0, 5'h1F);
      end
      cmp("address", pull, addr, 5'h1F);
      $display("strap and activity pass %0d done", r);
    end
    // Second pulse at 10 must keep the indicator past the first hold
    for (int k = 0; k < 42; k++) begin
      step(1'b0, {3'h0, k == 0 || k == 10}, k <= 30,
           5'h1F);
    end
    $display("collision hold done");
    step(1'b0, 4'h1, 1'b1, 5'h1F);
    for (int k = 0; k < 5; k++) begin
      step(1'b1, 4'hF, 1'b0, 5'h1F);
    end
    for (int k = 0; k < 4; k++) begin
      step(1'b0, 4'h0, 1'b0, 5'h1F);
    end
    cmp("address", pull, addr, 5'h1F);
    cmp("strap_done", 5'h01, {4'h0, strap_done}, 5'h01);
    $display("software reset done");
    @(negedge clk);
    give_verdict();
  end
endmodule
`default_nettype wire
